//--- eivp_regs.svh
`ifndef EIVP_REGS_SVH
`define EIVP_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define EIVP_OFS_CTRL 12'h000
`define EIVP_OFS_SRCFLAG 12'h004
`define EIVP_OFS_SRCEN 12'h008
`define EIVP_OFS_PEND 12'h00C
`define EIVP_OFS_VECTOR 12'h010
`define EIVP_OFS_ISTAT 12'h014
`define EIVP_OFS_IMASK 12'h018
`define EIVP_OFS_VTAB 12'h080

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define EIVP_CTRL_ACK 0
`define EIVP_CTRL_IE 1
`define EIVP_CTRL_FLAG 3
`define EIVP_CTRL_MOD 2
`define EIVP_CTRL_PE 4
`define EIVP_CTRL_PDD 5
`define EIVP_CTRL_LEVEL 6
`define EIVP_CTRL_RST 8'h00

// ----------------------------------------------------------------------------
// Vector table
// ----------------------------------------------------------------------------
`define EIVP_NUM_VEC 32
`define EIVP_FIRST_FREE 24
`define EIVP_VEC_PIN 2
`define EIVP_VEC_BASE 16'hFFC0
`define EIVP_VEC_TOP 16'hFFFE
`define EIVP_NO_VEC 6'h3F

`endif

//--- eivp_pkg.sv
package eivp_pkg;
  typedef enum logic [1:0] {EIVP_IDLE, EIVP_STACK, EIVP_FETCH} eivp_state_t;
  typedef logic [4:0] eivp_vec_t;
endpackage

//--- eivp_pick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface eivp_pick_if;
  logic [31:0] req;
  logic found;
  logic [4:0] num;
  modport host(output req, input found, input num);
  modport picker(input req, output found, output num);
endinterface
`default_nettype wire

//--- eivp_pick.sv
`timescale 1ns/1ps
`default_nettype none
module eivp_pick
  import eivp_pkg::*;
(
  eivp_pick_if.picker pk
);
  // Lowest number wins; scan downward so the last hit is the highest priority.
  always_comb begin
    pk.found = 1'b0;
    pk.num = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (pk.req[i]) begin
        pk.found = 1'b1;
        pk.num = 5'(i);
      end
    end
  end
endmodule
`default_nettype wire

//--- eivp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "eivp_regs.svh"
module eivp_top
  import eivp_pkg::*;
#(
  parameter int NUM_SRC = 32
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [11:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Pin and pad control
  input wire logic pin_n_in,
  output logic pullup_en_out,
  output logic stop_wake_out,
  // Peripheral sources, each a flag with its own enable
  input wire logic [NUM_SRC-1:0] src_flag_in,
  input wire logic [NUM_SRC-1:0] src_en_in,
  input wire logic [NUM_SRC-1:0] src_vec_map_in,
  // Core side
  input wire logic stop_mode_in,
  input wire logic global_mask_in,
  input wire logic instr_done_in,
  output logic pin_level_out,
  output logic core_req_out,
  output logic [4:0] vec_num_out,
  output logic [15:0] vec_addr_out,
  output logic stack_push_out,
  output logic [2:0] stack_item_out,
  output logic set_mask_out,
  output logic vec_fetch_out,
  output logic irq_out
);
  if (NUM_SRC != `EIVP_NUM_VEC) begin : g_bad_num_src
    $error("NUM_SRC must be 32");
  end

  // --------------------------------------------------------------------------
  // Control register and pin detection
  // --------------------------------------------------------------------------
  logic ext_pin_enable, edge_level_select, pullup_disable, pin_interrupt_enable;
  logic pin_event_flag;
  logic pin_s1, pin_s2, pin_prev;
  logic wr_ack;
  logic [6:0] istat, imask;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_prev <= 1'b1;
    end else begin
      pin_s1 <= pin_n_in;
      pin_s2 <= pin_s1;
      pin_prev <= pin_s2;
    end
  end

  logic pin_low, pin_fall;
  assign pin_low = ext_pin_enable & ~pin_s2;
  assign pin_fall = ext_pin_enable & pin_prev & ~pin_s2;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_event_flag <= 1'b0;
    end else if (pin_fall || (edge_level_select && pin_low)) begin
      pin_event_flag <= 1'b1;
    end else if (wr_ack) begin
      pin_event_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pullup_en_out <= 1'b0;
      pin_level_out <= 1'b1;
    end else begin
      pullup_en_out <= ext_pin_enable & ~pullup_disable;
      pin_level_out <= ext_pin_enable ? pin_s2 : 1'b1;
    end
  end
  // The wake term has to work with the clock stopped, so it is the one output that is
  // not registered: it reads the raw pin and goes straight to the clock control.
  logic stop_wake_async;
  assign stop_wake_async = stop_mode_in & ext_pin_enable & pin_interrupt_enable & ~pin_n_in;
  assign stop_wake_out = stop_wake_async;
  // The status bit for a wake uses the synchronised pin, never the raw one.
  logic stop_wake_seen;
  assign stop_wake_seen = stop_mode_in & ext_pin_enable & pin_interrupt_enable & ~pin_s2;

  // --------------------------------------------------------------------------
  // Request gathering and priority
  // --------------------------------------------------------------------------
  logic [31:0] vec_req;
  always_comb begin
    vec_req = 32'h0000_0000;
    for (int i = 0; i < `EIVP_FIRST_FREE; i++) begin
      vec_req[i] = src_vec_map_in[i] & src_flag_in[i] & src_en_in[i];
    end
    vec_req[`EIVP_VEC_PIN] = vec_req[`EIVP_VEC_PIN] | (pin_event_flag & pin_interrupt_enable);
  end

  eivp_pick_if pk();
  assign pk.req = vec_req;
  eivp_pick u_pick (.pk(pk));

  // --------------------------------------------------------------------------
  // Entry sequencer
  // --------------------------------------------------------------------------
  eivp_state_t state;
  logic [2:0] push_cnt;
  // The core shows the raised mask one cycle after the set pulse, so the cycle of
  // that pulse is blocked as well; otherwise one request would be entered twice.
  logic entry_go;
  assign entry_go = state == EIVP_IDLE && pk.found && !global_mask_in && instr_done_in && !set_mask_out;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= EIVP_IDLE;
      push_cnt <= 3'h0;
      stack_push_out <= 1'b0;
      stack_item_out <= 3'h0;
      set_mask_out <= 1'b0;
      vec_fetch_out <= 1'b0;
      vec_num_out <= 5'h00;
      vec_addr_out <= 16'h0000;
    end else begin
      stack_push_out <= 1'b0;
      set_mask_out <= 1'b0;
      vec_fetch_out <= 1'b0;
      unique case (state)
        EIVP_IDLE: begin
          if (entry_go) begin
            state <= EIVP_STACK;
            push_cnt <= 3'h0;
          end
        end
        EIVP_STACK: begin
          stack_push_out <= 1'b1;
          stack_item_out <= push_cnt; // 0 low PC,1 high PC,2 index,3 acc,4 codes
          push_cnt <= push_cnt + 3'h1;
          if (push_cnt == 3'h4) begin
            state <= EIVP_FETCH;
          end
        end
        EIVP_FETCH: begin
          set_mask_out <= 1'b1;
          vec_fetch_out <= 1'b1;
          vec_num_out <= pk.num;
          vec_addr_out <= `EIVP_VEC_TOP - {10'h000, pk.num, 1'b0};
          state <= EIVP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      core_req_out <= 1'b0;
    end else begin
      core_req_out <= pk.found;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status and AHB-Lite slave
  // --------------------------------------------------------------------------
  // Read data is taken in the address phase, so a read that follows a write to the
  // same register without a gap returns the value from before that write.
  logic dp_wr, dp_rd;
  logic [11:0] dp_addr;
  logic ap_take;
  assign ap_take = hsel_in & hready_in & htrans_in[1];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      dp_addr <= 12'h000;
    end else if (hready_in) begin
      dp_wr <= ap_take & hwrite_in;
      dp_rd <= ap_take & ~hwrite_in;
      dp_addr <= haddr_in;
    end
  end
  assign wr_ack = dp_wr && dp_addr == `EIVP_OFS_CTRL && hwdata_in[`EIVP_CTRL_ACK];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_pin_enable <= 1'b0;
      edge_level_select <= 1'b0;
      pullup_disable <= 1'b0;
      pin_interrupt_enable <= 1'b0;
      imask <= 7'h00;
    end else if (dp_wr) begin
      if (dp_addr == `EIVP_OFS_CTRL) begin
        ext_pin_enable <= hwdata_in[`EIVP_CTRL_PE];
        edge_level_select <= hwdata_in[`EIVP_CTRL_MOD];
        pullup_disable <= hwdata_in[`EIVP_CTRL_PDD];
        pin_interrupt_enable <= hwdata_in[`EIVP_CTRL_IE];
      end
      if (dp_addr == `EIVP_OFS_IMASK) begin
        imask <= hwdata_in[6:0];
      end
    end
  end

  // Events: 0 pin event, 1 pin fall, 2 vector fetched, 3 request seen, 4 stack start,
  // 5 stop wake seen, 6 ack blocked by level hold.
  logic [6:0] ev;
  assign ev = {wr_ack & edge_level_select & pin_low, stop_wake_seen,
               entry_go,
               pk.found & ~core_req_out, vec_fetch_out, pin_fall, pin_fall | (edge_level_select & pin_low)};
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      istat <= 7'h00;
    end else begin
      // Set wins over a write-one clear in the same cycle.
      istat <= (istat & ~((dp_wr && dp_addr == `EIVP_OFS_ISTAT) ? hwdata_in[6:0] : 7'h00)) | ev;
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(istat & imask);
    end
  end

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr_in >= `EIVP_OFS_VTAB && haddr_in < `EIVP_OFS_VTAB + 12'h080) begin
      // Word k holds the address of vector 31 - k, so the table rises by two per word.
      rd_mux = {16'h0000, `EIVP_VEC_BASE + {10'h000, haddr_in[6:2], 1'b0}};
    end else begin
      unique case (haddr_in)
        `EIVP_OFS_CTRL: rd_mux = {25'h0, ~pin_s2 & ext_pin_enable, pullup_disable, ext_pin_enable,
                                   pin_event_flag, edge_level_select, pin_interrupt_enable, 1'b0};
        `EIVP_OFS_SRCFLAG: rd_mux = src_flag_in;
        `EIVP_OFS_SRCEN: rd_mux = src_en_in;
        `EIVP_OFS_PEND: rd_mux = vec_req;
        `EIVP_OFS_VECTOR: rd_mux = {26'h0, pk.found, pk.num};
        `EIVP_OFS_ISTAT: rd_mux = {25'h0, istat};
        `EIVP_OFS_IMASK: rd_mux = {25'h0, imask};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else if (ap_take && !hwrite_in) begin
      hrdata_out <= rd_mux;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_fall_sets_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    pin_fall |=> pin_event_flag) else $error("falling pin did not set flag");
  a_level_holds_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    edge_level_select && pin_low |=> pin_event_flag) else $error("level hold lost flag");
  a_disabled_pin_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
    !ext_pin_enable && !pin_event_flag |=> !pin_event_flag) else $error("disabled pin set flag");
  a_ack_clears: assert property (@(posedge clk_in) disable iff (rst_in)
    wr_ack && !pin_fall && !(edge_level_select && pin_low) |=> !pin_event_flag) else $error("ack failed");
  a_pullup_state: assert property (@(posedge clk_in) disable iff (rst_in)
    ##1 pullup_en_out == $past(ext_pin_enable & ~pullup_disable)) else $error("pullup wrong");
  a_no_free_vec: assert property (@(posedge clk_in) disable iff (rst_in)
    pk.found |-> pk.num < 5'h18) else $error("free vector picked");
  a_prio_pick: assert property (@(posedge clk_in) disable iff (rst_in)
    pk.found |-> (vec_req & ((32'h1 << pk.num) - 32'h1)) == 32'h0) else $error("not highest priority");
  a_gated_req: assert property (@(posedge clk_in) disable iff (rst_in)
    pk.found |-> vec_req[pk.num]) else $error("ungated request");
  a_entry_seq: assert property (@(posedge clk_in) disable iff (rst_in)
    entry_go |=> ##1 stack_push_out[*5] ##1
    (set_mask_out && vec_fetch_out)) else $error("entry sequence wrong");
  a_vec_addr: assert property (@(posedge clk_in) disable iff (rst_in)
    vec_fetch_out |-> vec_addr_out == 16'hFFFE - {10'h000, vec_num_out, 1'b0}) else $error("bad vector addr");
  a_pin_poll: assert property (@(posedge clk_in) disable iff (rst_in)
    pin_event_flag && !pin_interrupt_enable && src_flag_in == '0 |-> !vec_req[2]) else $error("poll requested");
  a_pin_level: assert property (@(posedge clk_in) disable iff (rst_in)
    ext_pin_enable && !pin_s2 |=> !pin_level_out) else $error("pin level not shown");
  a_wake_path: assert property (@(posedge clk_in) disable iff (rst_in)
    stop_mode_in && ext_pin_enable && pin_interrupt_enable && !pin_n_in |-> stop_wake_out) else $error("no wake");
  a_reentry_block: assert property (@(posedge clk_in) disable iff (rst_in)
    set_mask_out |=> state == EIVP_IDLE) else $error("request entered twice");
  a_mask_holds_off: assert property (@(posedge clk_in) disable iff (rst_in)
    global_mask_in && state == EIVP_IDLE |=> state == EIVP_IDLE) else $error("entry while masked");
  a_items_order: assert property (@(posedge clk_in) disable iff (rst_in)
    stack_push_out && $past(stack_push_out) |-> stack_item_out == $past(stack_item_out) + 3'h1)
    else $error("stack order wrong");
  a_fetch_pair: assert property (@(posedge clk_in) disable iff (rst_in)
    vec_fetch_out == set_mask_out) else $error("mask and fetch apart");
  a_core_req: assert property (@(posedge clk_in) disable iff (rst_in)
    vec_req == 32'h0000_0000 |=> !core_req_out) else $error("request without source");
  a_shared_or: assert property (@(posedge clk_in) disable iff (rst_in)
    pin_event_flag && pin_interrupt_enable |-> vec_req[`EIVP_VEC_PIN]) else $error("pin request lost");
  a_irq_level: assert property (@(posedge clk_in) disable iff (rst_in)
    |(istat & imask) |=> irq_out) else $error("interrupt output low");
  a_status_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
    istat[0] && !(dp_wr && dp_addr == `EIVP_OFS_ISTAT && hwdata_in[0]) |=> istat[0]) else $error("status lost");
  a_okay_resp: assert property (@(posedge clk_in) disable iff (rst_in)
    hreadyout_out && !hresp_out) else $error("bus response not okay");

  // --------------------------------------------------------------------------
  // Cover properties
  // --------------------------------------------------------------------------
  c_pin_edge: cover property (@(posedge clk_in) disable iff (rst_in) pin_fall);
  c_level_block: cover property (@(posedge clk_in) disable iff (rst_in) wr_ack && edge_level_select && pin_low);
  c_fetch: cover property (@(posedge clk_in) disable iff (rst_in) vec_fetch_out);
  c_entry: cover property (@(posedge clk_in) disable iff (rst_in) entry_go);
  c_wake: cover property (@(posedge clk_in) disable iff (rst_in) stop_wake_async);
endmodule
`default_nettype wire

//--- eivp_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module eivp_far_model (
  // Clock, reset and commands from the bench
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pin_low_in,
  input wire logic slow_in,
  input wire logic unmask_in,
  // Core side of the block
  input wire logic stack_push_in,
  input wire logic [2:0] stack_item_in,
  input wire logic set_mask_in,
  input wire logic vec_fetch_in,
  // Pin and core levels
  output logic pin_n_out,
  output logic global_mask_out,
  output logic instr_done_out,
  output logic [14:0] push_log_out,
  output logic [7:0] fetch_count_out
);
  logic [1:0] phase;

  // The line is pulled high whenever the source lets go of it.
  assign pin_n_out = pin_low_in ? 1'b0 : 1'b1;
  // A slow core only finishes an instruction every fourth cycle.
  assign instr_done_out = slow_in ? (phase == 2'h3) : 1'b1;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase <= 2'h0;
      global_mask_out <= 1'b1;
      push_log_out <= 15'h0000;
      fetch_count_out <= 8'h00;
    end else begin
      phase <= phase + 2'h1;
      if (set_mask_in) begin
        global_mask_out <= 1'b1;
      end else if (unmask_in) begin
        global_mask_out <= 1'b0;
      end
      if (stack_push_in) begin
        push_log_out <= {push_log_out[11:0], stack_item_in};
      end
      if (vec_fetch_in) begin
        fetch_count_out <= fetch_count_out + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- eivp_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eivp_top_tb;
  import eivp_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rdat, src_flag = 32'h0, src_en = 32'h0;
  logic [31:0] src_map = 32'h00FFFFFF;
  logic hreadyout, hresp, pin_n, pullup_en, pin_level, core_req, irq, gmask, idone, wake;
  logic push, set_mask, fetch, pin_low = 1'b0, slow = 1'b0, unmask = 1'b0, stop = 1'b0;
  logic [4:0] vec_num;
  logic [15:0] vec_addr;
  logic [2:0] item;
  logic [14:0] push_log;
  logic [7:0] fetch_count;
  int mismatches = 0, total_checks = 0;

  always #4 clk_in = ~clk_in;

  eivp_top dut_u (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
    .hresp_out(hresp), .pin_n_in(pin_n), .pullup_en_out(pullup_en), .stop_wake_out(wake),
    .src_flag_in(src_flag), .src_en_in(src_en), .src_vec_map_in(src_map),
    .stop_mode_in(stop), .global_mask_in(gmask), .instr_done_in(idone),
    .pin_level_out(pin_level), .core_req_out(core_req), .vec_num_out(vec_num),
    .vec_addr_out(vec_addr), .stack_push_out(push), .stack_item_out(item),
    .set_mask_out(set_mask), .vec_fetch_out(fetch), .irq_out(irq));

  eivp_far_model far_u (.clk_in(clk_in), .rst_in(rst_in), .pin_low_in(pin_low),
    .slow_in(slow), .unmask_in(unmask), .stack_push_in(push), .stack_item_in(item),
    .set_mask_in(set_mask), .vec_fetch_in(fetch), .pin_n_out(pin_n),
    .global_mask_out(gmask), .instr_done_out(idone), .push_log_out(push_log),
    .fetch_count_out(fetch_count));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bounded wait for the slave; a hung bus ends the run.
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rdat = hrdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic set_pin(input logic low);
    @(posedge clk_in);
    pin_low <= low;
    cyc(6);
  endtask

  task automatic t_reset_vals();
    check("hreadyout", hreadyout, 1'b1);
    check("hresp", hresp, 1'b0);
    check("pin level", pin_level, 1'b1);
    bus(1'b0, 12'h000, 32'h0);
    check("ctrl", rdat, 32'h0);
    bus(1'b0, 12'h040, 32'h0);
    check("unmapped", rdat, 32'h0);
  endtask

  task automatic t_pin_edge();
    set_pin(1'b1);
    bus(1'b0, 12'h000, 32'h0);
    check("ctrl gated", rdat, 32'h0);
    check("pin level off", pin_level, 1'b1);
    set_pin(1'b0);
    bus(1'b1, 12'h000, 32'h10);
    cyc(2);
    check("pullup on", pullup_en, 1'b1);
    bus(1'b1, 12'h000, 32'h30);
    cyc(2);
    check("pullup off", pullup_en, 1'b0);
    bus(1'b1, 12'h000, 32'h10);
    set_pin(1'b1);
    bus(1'b0, 12'h000, 32'h0);
    check("edge flag", rdat, 32'h58);
    check("pin level", pin_level, 1'b0);
    check("no request", core_req, 1'b0);
    set_pin(1'b0);
    bus(1'b1, 12'h000, 32'h11);
    bus(1'b0, 12'h000, 32'h0);
    check("ack", rdat, 32'h10);
  endtask

  task automatic t_level_hold();
    bus(1'b1, 12'h000, 32'h14);
    set_pin(1'b1);
    bus(1'b1, 12'h000, 32'h15);
    bus(1'b0, 12'h000, 32'h0);
    check("level hold", rdat, 32'h5C);
    set_pin(1'b0);
    bus(1'b1, 12'h000, 32'h15);
    bus(1'b0, 12'h000, 32'h0);
    check("level ack", rdat, 32'h14);
  endtask

  task automatic enter(input logic [4:0] num, input logic [15:0] addr);
    int n;
    logic [7:0] c0;
    c0 = fetch_count;
    @(posedge clk_in);
    unmask <= 1'b1;
    @(posedge clk_in);
    unmask <= 1'b0;
    for (n = 0; n < 300 && fetch_count == c0; n++) @(posedge clk_in);
    if (n >= 300) begin
      mismatches++;
      tally_and_finish();
    end
    cyc(1);
    check("stack order", push_log, {3'h0, 3'h1, 3'h2, 3'h3, 3'h4});
    check("mask set", gmask, 1'b1);
    check("vector", vec_num, num);
    check("vector addr", vec_addr, addr);
  endtask

  task automatic t_pin_entry();
    slow <= 1'b1;
    bus(1'b1, 12'h000, 32'h12);
    set_pin(1'b1);
    check("request", core_req, 1'b1);
    enter(5'h02, 16'hFFFA);
    set_pin(1'b0);
    bus(1'b1, 12'h000, 32'h13);
    cyc(3);
    check("request gone", core_req, 1'b0);
  endtask

  task automatic t_sources();
    @(posedge clk_in);
    src_flag <= 32'h100002A0;
    src_en <= 32'h50000380;
    cyc(3);
    bus(1'b0, 12'h00C, 32'h0);
    check("pending", rdat, 32'h280);
    bus(1'b0, 12'h010, 32'h0);
    check("picked", rdat, 32'h27);
    enter(5'h07, 16'hFFF0);
    bus(1'b0, 12'h080, 32'h0);
    check("table low", rdat, 32'hFFC0);
    bus(1'b0, 12'h0FC, 32'h0);
    check("table top", rdat, 32'hFFFE);
    @(posedge clk_in);
    src_flag <= 32'h0;
    cyc(3);
    check("sources idle", core_req, 1'b0);
  endtask

  task automatic t_wake();
    @(posedge clk_in);
    stop <= 1'b1;
    set_pin(1'b1);
    check("stop wake", wake, 1'b1);
    @(posedge clk_in);
    stop <= 1'b0;
    cyc(2);
    check("wake in run", wake, 1'b0);
    set_pin(1'b0);
    bus(1'b1, 12'h000, 32'h13);
  endtask

  task automatic t_irq();
    bus(1'b1, 12'h018, 32'h0);
    cyc(2);
    check("irq masked", irq, 1'b0);
    bus(1'b1, 12'h018, 32'h1);
    cyc(2);
    check("irq up", irq, 1'b1);
    bus(1'b1, 12'h014, 32'h1);
    cyc(2);
    check("irq clear", irq, 1'b0);
    bus(1'b0, 12'h014, 32'h0);
    check("status bit", rdat[0], 1'b0);
  endtask

  initial begin
    cyc(2);
    rst_in <= 1'b0;
    t_reset_vals();
    t_pin_edge();
    t_level_hold();
    t_pin_entry();
    t_sources();
    t_wake();
    t_irq();
    tally_and_finish();
  end
endmodule
`default_nettype wire
